/* logic/hsc_map.svh */
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH

// Word-aligned byte addresses of the register words.
`define HSC_CTRL_ADDR 8'h00
`define HSC_STAT_ADDR 8'h04
`define HSC_RCNT_ADDR 8'h08

// Control word field positions.
`define HSC_CTRL_OVR     0
`define HSC_CTRL_CODE_LO 1
`define HSC_CTRL_CODE_HI 3
`define HSC_CTRL_MASKUV  4
`define HSC_CTRL_MASKOV  5
`define HSC_CTRL_W       6

// Status word field positions; bits 4:0 are sticky, write one to clear.
`define HSC_STAT_FLAGS_HI 4
`define HSC_STAT_LATCHED  5
`define HSC_STAT_PGOOD    6

// Reset values.
`define HSC_CTRL_RST  6'h00
`define HSC_FLAGS_RST 5'h00

// Number of full retry ramps before the final ramp down.
`define HSC_LAST_RAMP 3'h7

`endif

/* logic/hsc_pkg.sv */
`default_nettype none
package hsc_pkg;

   // Sequencer states.
   typedef enum logic [2:0] {
      HSC_OFF, HSC_RUN, HSC_FTIME, HSC_LATCH, HSC_RUP, HSC_RDOWN
   } hsc_state_t;

   // Classic Wishbone request from the master.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } hsc_wbreq_t;

   // Timer node comparators, high when the node is above each level.
   typedef struct packed {
      logic aboveHigh;
      logic aboveMid;
      logic aboveLow;
   } hsc_timer_t;

   // Enables of the gate and timer current sources and hysteresis sources.
   typedef struct packed {
      logic gateCharge;
      logic gatePulldown;
      logic timerCharge;
      logic timerFastSink;
      logic timerWeakSink;
      logic uvHyst;
      logic ovHyst;
   } hsc_drive_t;

   // Sticky fault flags; bit 0 is the undervoltage fault.
   typedef struct packed {
      logic diagOv;
      logic diagUv;
      logic inSum;
      logic ovFault;
      logic uvFault;
   } hsc_flags_t;

   // Whole state of the sequencer.
   typedef struct packed {
      hsc_state_t  fsm;
      logic [2:0]  rampCnt;
      logic [4:0]  retryDone;
      logic        restartPend;
      logic        uvArmed;
      logic [5:0]  ctrl;
      hsc_flags_t  flags;
      hsc_drive_t  drive;
      logic        pGood;
      logic        alert;
      logic        wbAck;
      logic [31:0] wbDat;
   } hsc_regs_t;

endpackage : hsc_pkg
`default_nettype wire

/* logic/hsc_fault_restart.sv */
// How it works
// - Limiting active enables timer charge source.
// - Limiting ends early: run, fast timer sink.
// - Timer high: gate pulldown, then restart policy.
// - Retry pin high: latch off, weak sink.
// - Latched off until enable pulled low.
// - Restart only with timer below low level.
// - Latched-off status flag follows latched state.
// - Seven ramps between high and mid levels.
// - Eighth fall to low level re-enables gate.
// - Fault persisting repeats timeout and restart.
// - Pin or register chooses retry count.
// - Undervoltage: UV hysteresis on, gate off.
// - Enable above and insertion done: gate on.
// - Undervoltage sets flags and maskable alert.
// - Overvoltage turns gate off, OV hysteresis on only while enable is high.
// - Overvoltage sets flags and maskable alert.
// - Enable released restarts with limiting active.
// - Power good follows feedback comparator.
// - Power good low on UV or OV.
// - Retry pin low gives automatic retries.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_map.svh"

module hsc_fault_restart (
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic              undervolt_enable_in,
   input  wire logic              overvolt_in,
   input  wire logic              feedback_cmp_in,
   input  wire logic              retrySelIn,
   input  wire logic              insertDoneIn,
   input  wire logic              limitActiveIn,
   input  wire hsc_pkg::hsc_timer_t timerCmp,
   input  wire hsc_pkg::hsc_wbreq_t wbReq,
   output logic                   wbAck,
   output logic [31:0]            wbDat,
   output hsc_pkg::hsc_drive_t    drive,
   output logic                   power_good_out,
   output logic                   alert_out
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Retry count for a register code; codes 6 and 7 mean unlimited.
   function automatic logic [4:0] retryLimit(input logic [2:0] code);
      logic [4:0] lim;
      lim = 5'h00;
      unique case (code)
         3'h0: lim = 5'h00;
         3'h1: lim = 5'h01;
         3'h2: lim = 5'h02;
         3'h3: lim = 5'h04;
         3'h4: lim = 5'h08;
         3'h5: lim = 5'h10;
         default: lim = 5'h1f;
      endcase
      return lim;
   endfunction : retryLimit

   // Source enables that belong to each state.
   function automatic hsc_pkg::hsc_drive_t driveFor(input hsc_pkg::hsc_state_t s);
      hsc_pkg::hsc_drive_t dr;
      dr = '0;
      unique case (s)
         hsc_pkg::HSC_OFF: begin
            dr.gatePulldown  = 1'b1;
            dr.timerFastSink = 1'b1;
         end
         hsc_pkg::HSC_RUN: begin
            dr.gateCharge    = 1'b1;
            dr.timerFastSink = 1'b1;
         end
         hsc_pkg::HSC_FTIME: begin
            dr.gateCharge  = 1'b1;
            dr.timerCharge = 1'b1;
         end
         hsc_pkg::HSC_LATCH: begin
            dr.gatePulldown  = 1'b1;
            dr.timerWeakSink = 1'b1;
         end
         hsc_pkg::HSC_RUP: begin
            dr.gatePulldown = 1'b1;
            dr.timerCharge  = 1'b1;
         end
         hsc_pkg::HSC_RDOWN: begin
            dr.gatePulldown  = 1'b1;
            dr.timerWeakSink = 1'b1;
         end
      endcase
      return dr;
   endfunction : driveFor

   ////////////////////////////////////////////////////////////////////////
   // State and derived terms.

   hsc_pkg::hsc_regs_t q;        // Registered state.
   hsc_pkg::hsc_regs_t d;        // Next state.

   logic       supplyOk;         // Inside the UV/OV window.
   logic       reqLive;          // Bus request not yet answered.
   logic       ackWrite;         // Write that takes effect this edge.
   logic       retryInf;         // Unlimited retries selected.
   logic       retryOk;          // Another retry is allowed.
   logic [4:0] flagClr;          // Write-one-to-clear mask.

   // Comparators arrive already synchronous to clock.
   assign supplyOk = undervolt_enable_in & ~overvolt_in;
   assign reqLive  = wbReq.cyc & wbReq.stb & ~q.wbAck;
   assign ackWrite = wbReq.cyc & wbReq.stb & wbReq.we & q.wbAck & wbReq.sel[0];

   // Pin gives none or unlimited; register override gives a count.
   assign retryInf = q.ctrl[`HSC_CTRL_OVR]
                     ? (q.ctrl[`HSC_CTRL_CODE_HI:`HSC_CTRL_CODE_LO] > 3'h5)
                     : ~retrySelIn;
   assign retryOk  = retryInf | (q.ctrl[`HSC_CTRL_OVR]
                     & (q.retryDone < retryLimit(q.ctrl[`HSC_CTRL_CODE_HI:`HSC_CTRL_CODE_LO])));

   assign flagClr = (ackWrite && wbReq.adr == `HSC_STAT_ADDR)
                    ? wbReq.dat[`HSC_STAT_FLAGS_HI:0] : 5'h00;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Sequencer, flags and bus slave in one pass over a copy of the state.
   always_comb begin
      d = q;

      // Answer each request one cycle after it appears.
      d.wbAck = reqLive;
      d.wbDat = 32'h0000_0000;
      if (reqLive) begin
         unique case (wbReq.adr)
            `HSC_CTRL_ADDR: d.wbDat = {26'h0, q.ctrl};
            `HSC_STAT_ADDR: d.wbDat = {25'h0, q.pGood, q.fsm == hsc_pkg::HSC_LATCH, q.flags};
            `HSC_RCNT_ADDR: d.wbDat = {27'h0, q.retryDone};
            default:        d.wbDat = 32'h0000_0000;
         endcase
      end
      if (ackWrite && wbReq.adr == `HSC_CTRL_ADDR) begin
         d.ctrl = wbReq.dat[`HSC_CTRL_W-1:0];
      end

      // Undervolt only counts once the enable input has been high once.
      d.uvArmed = q.uvArmed | undervolt_enable_in;

      // Set wins over a clear in the same cycle.
      d.flags = q.flags & ~flagClr;
      if (q.uvArmed && !undervolt_enable_in) begin
         d.flags.uvFault = 1'b1;
         d.flags.diagUv  = 1'b1;
         d.flags.inSum   = 1'b1;
      end
      if (overvolt_in) begin
         d.flags.ovFault = 1'b1;
         d.flags.diagOv  = 1'b1;
         d.flags.inSum   = 1'b1;
      end

      // Sequencer.
      unique case (q.fsm)
         hsc_pkg::HSC_OFF: begin
            // A fresh power-up forgets earlier retries.
            d.retryDone   = 5'h00;
            d.restartPend = 1'b0;
            if (supplyOk && insertDoneIn) begin
               d.fsm = hsc_pkg::HSC_RUN;
            end
         end
         hsc_pkg::HSC_RUN: begin
            if (!supplyOk) begin
               d.fsm = hsc_pkg::HSC_OFF;
            end else if (limitActiveIn) begin
               d.fsm = hsc_pkg::HSC_FTIME;
            end
         end
         hsc_pkg::HSC_FTIME: begin
            if (!supplyOk) begin
               d.fsm = hsc_pkg::HSC_OFF;
            end else if (timerCmp.aboveHigh) begin
               // Timeout: gate off, then retry or latch.
               d.rampCnt = 3'h0;
               if (retryOk) begin
                  d.fsm = hsc_pkg::HSC_RDOWN;
                  if (q.retryDone != 5'h1f) begin
                     d.retryDone = q.retryDone + 5'h01;
                  end
               end else begin
                  d.fsm = hsc_pkg::HSC_LATCH;
               end
            end else if (!limitActiveIn) begin
               d.fsm = hsc_pkg::HSC_RUN;
            end
         end
         hsc_pkg::HSC_LATCH: begin
            // A short enable pulse is remembered until the timer drains.
            if (!undervolt_enable_in) begin
               d.restartPend = 1'b1;
            end
            if ((q.restartPend || !undervolt_enable_in) && !timerCmp.aboveLow) begin
               d.fsm = hsc_pkg::HSC_OFF;
            end
         end
         hsc_pkg::HSC_RDOWN: begin
            if (!supplyOk) begin
               d.fsm = hsc_pkg::HSC_OFF;
            end else if (q.rampCnt == `HSC_LAST_RAMP) begin
               if (!timerCmp.aboveLow) begin
                  d.fsm = hsc_pkg::HSC_RUN;
               end
            end else if (!timerCmp.aboveMid) begin
               d.rampCnt = q.rampCnt + 3'h1;
               d.fsm     = hsc_pkg::HSC_RUP;
            end
         end
         hsc_pkg::HSC_RUP: begin
            if (!supplyOk) begin
               d.fsm = hsc_pkg::HSC_OFF;
            end else if (timerCmp.aboveHigh) begin
               d.fsm = hsc_pkg::HSC_RDOWN;
            end
         end
      endcase

      // Sources follow the next state so the outputs match the state.
      d.drive        = driveFor(d.fsm);
      d.drive.uvHyst = ~undervolt_enable_in;
      d.drive.ovHyst = overvolt_in & undervolt_enable_in;

      d.pGood = feedback_cmp_in & supplyOk;
      d.alert = (d.flags.uvFault & ~d.ctrl[`HSC_CTRL_MASKUV])
              | (d.flags.ovFault & ~d.ctrl[`HSC_CTRL_MASKOV]);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   // Reset puts the gate off with the timer draining.
   always_ff @(posedge clock) begin
      if (srst) begin
         q             <= '0;
         q.fsm         <= hsc_pkg::HSC_OFF;
         q.ctrl        <= `HSC_CTRL_RST;
         q.flags       <= `HSC_FLAGS_RST;
         q.drive       <= '0;
         q.drive.gatePulldown  <= 1'b1;
         q.drive.timerFastSink <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign wbAck          = q.wbAck;
   assign wbDat          = q.wbDat;
   assign drive          = q.drive;
   assign power_good_out = q.pGood;
   assign alert_out      = q.alert;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Final fall of a retry reaching the low level with supply good.
   sequence lastFallLow;
      q.fsm == hsc_pkg::HSC_RDOWN && q.rampCnt == `HSC_LAST_RAMP
      && !timerCmp.aboveLow && supplyOk;
   endsequence

   // Timeout reached in the fault-timer state with supply good, whether or not still limiting.
   sequence timeoutHit;
      q.fsm == hsc_pkg::HSC_FTIME && supplyOk && timerCmp.aboveHigh;
   endsequence

   chk_limit_charge: assert property (
      q.fsm == hsc_pkg::HSC_RUN && supplyOk && limitActiveIn |=> drive.timerCharge && drive.gateCharge)
      else $error("timer charge not on while limiting");

   chk_early_return: assert property (
      q.fsm == hsc_pkg::HSC_FTIME && supplyOk && !timerCmp.aboveHigh && !limitActiveIn
      |=> q.fsm == hsc_pkg::HSC_RUN && drive.timerFastSink && !drive.timerCharge)
      else $error("no fast discharge after limiting ended");

   chk_timeout_off: assert property (
      timeoutHit |=> drive.gatePulldown && !drive.gateCharge)
      else $error("gate not pulled down at timeout");

   chk_latch_hold: assert property (
      q.fsm == hsc_pkg::HSC_LATCH |-> drive.timerWeakSink && !drive.gateCharge)
      else $error("latched state drives wrong sources");

   chk_latch_timer: assert property (
      q.fsm == hsc_pkg::HSC_LATCH && timerCmp.aboveLow |=> q.fsm == hsc_pkg::HSC_LATCH)
      else $error("restart taken with timer above low level");

   chk_eighth_fall: assert property (
      lastFallLow |=> drive.gateCharge ##0 q.fsm == hsc_pkg::HSC_RUN)
      else $error("gate not re-enabled after last ramp");

   chk_uv_hold: assert property (
      !undervolt_enable_in |=> drive.uvHyst && !drive.ovHyst && !drive.gateCharge)
      else $error("undervoltage does not hold gate off");

   chk_ov_off: assert property (
      overvolt_in && undervolt_enable_in |=> drive.ovHyst && !drive.gateCharge)
      else $error("overvoltage does not turn gate off");

   chk_pgood_low: assert property (
      !undervolt_enable_in || overvolt_in |=> !power_good_out)
      else $error("power good high outside window");

   chk_uv_flag: assert property (
      q.uvArmed && !undervolt_enable_in |=> q.flags.uvFault && q.flags.inSum && q.flags.diagUv)
      else $error("undervoltage flag not set");

   // Timeout decided by the pin, with no register override in force.
   sequence pinTimeout;
      timeoutHit ##0 !q.ctrl[`HSC_CTRL_OVR];
   endsequence

   // Restart policy at the end of a timeout; the register beats the pin.
   chk_pin_latch: assert property (
      pinTimeout ##0 retrySelIn |=> q.fsm == hsc_pkg::HSC_LATCH && drive.timerWeakSink)
      else $error("retry pin high did not latch off");

   chk_pin_retry: assert property (
      pinTimeout ##0 !retrySelIn |=> q.fsm == hsc_pkg::HSC_RDOWN && drive.gatePulldown)
      else $error("retry pin low did not start a retry");

   chk_zero_retry: assert property (
      timeoutHit ##0 (q.ctrl[`HSC_CTRL_OVR] && q.ctrl[`HSC_CTRL_CODE_HI:`HSC_CTRL_CODE_LO] == 3'h0)
      |=> q.fsm == hsc_pkg::HSC_LATCH)
      else $error("zero retry setting did not latch off");

   // A retry ramp that reaches the mid level turns back up until the count is spent.
   chk_ramp_up: assert property (
      q.fsm == hsc_pkg::HSC_RDOWN && supplyOk && q.rampCnt != `HSC_LAST_RAMP && !timerCmp.aboveMid
      |=> q.fsm == hsc_pkg::HSC_RUP && drive.timerCharge && !drive.gateCharge)
      else $error("retry ramp did not turn back up at mid level");

   chk_gate_on: assert property (
      q.fsm == hsc_pkg::HSC_OFF && supplyOk && insertDoneIn
      |=> drive.gateCharge && !drive.gatePulldown && !drive.uvHyst)
      else $error("gate not turned on after insertion delay");

   // Flags and alert; the alert may only stay quiet when its mask is set.
   chk_ov_flag: assert property (
      overvolt_in |=> q.flags.ovFault && q.flags.diagOv && q.flags.inSum)
      else $error("overvoltage flags not set");

   chk_uv_alert: assert property (
      q.uvArmed && !undervolt_enable_in |=> alert_out || q.ctrl[`HSC_CTRL_MASKUV])
      else $error("undervoltage alert missing");

   chk_ov_alert: assert property (
      overvolt_in |=> alert_out || q.ctrl[`HSC_CTRL_MASKOV])
      else $error("overvoltage alert missing");

   chk_pgood_high: assert property (
      feedback_cmp_in && supplyOk |=> power_good_out)
      else $error("power good not released");

   // Software must see the latched state in any status read taken during it.
   chk_latch_status: assert property (
      q.fsm == hsc_pkg::HSC_LATCH && reqLive && wbReq.adr == `HSC_STAT_ADDR
      |=> wbDat[`HSC_STAT_LATCHED])
      else $error("latched-off status bit not shown");

   // Without an enable pull-down the latch holds, however low the timer falls.
   chk_restart_wait: assert property (
      q.fsm == hsc_pkg::HSC_LATCH && undervolt_enable_in && !q.restartPend
      |=> q.fsm == hsc_pkg::HSC_LATCH)
      else $error("latched state left without a restart request");

endmodule : hsc_fault_restart
`default_nettype wire

/* sim/hsc_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural timer capacitor: the node level moves by the enabled sources.
module hsc_timer_model (
   input  wire logic                clock,
   input  wire hsc_pkg::hsc_drive_t drive,
   output var  hsc_pkg::hsc_timer_t timerCmp
);
   int lvl = 0;   // Node level in units of 10 mV.
   int nxt;       // Unclamped next level.

   ////////////////////////////////////////////////////////////////////////////////
   // Charge is fast, the weak sink slow, so a full retry cycle takes hundreds of clocks.
   always_comb begin
      nxt = lvl + (drive.timerCharge ? 10 : 0) - (drive.timerFastSink ? 50 : 0) - (drive.timerWeakSink ? 2 : 0);
   end

   // The node cannot go below ground or above the supply.
   always @(posedge clock) begin
      lvl <= (nxt < 0) ? 0 : ((nxt > 200) ? 200 : nxt);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparators at 1.7 V, 1 V and 0.3 V, handed over as plain levels.
   assign timerCmp = {lvl >= 170, lvl >= 100, lvl >= 30};
endmodule : hsc_timer_model
`default_nettype wire

/* sim/test_hot_swap_fault_restart_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_hot_swap_fault_restart_control;
   typedef struct packed {logic uv; logic ov; logic fb; logic pg; logic al; logic [6:0] drv;} hsc_row_t;

   logic                clock = 1'b0;     // 25 MHz bench clock.
   logic                srst, uv, ov, fb; // Reset and comparator levels.
   logic                retrySel, insDone, limAct;
   hsc_pkg::hsc_wbreq_t wbReq;            // Bus request driven by the bench.
   hsc_pkg::hsc_timer_t timerCmp;         // From the timer model.
   hsc_pkg::hsc_drive_t drive;            // Source enables from the design.
   logic                wbAck, pGood, alert;
   logic [31:0]         wbDat, rd;
   logic                rupPrev = 1'b0;   // Charge-up ramp seen last cycle.
   int                  failures = 0, comparisons = 0, ramps = 0, r0, i;
   // Supply-window rows: levels in, power good, alert and drive expected out.
   hsc_row_t rows [5] = '{'{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h48}, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7'h48},
                          '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 7'h2a}, '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 7'h29},
                          '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 7'h48}};

   always #20 clock = ~clock;

   hsc_fault_restart uut (.clock(clock), .srst(srst), .undervolt_enable_in(uv), .overvolt_in(ov),
      .feedback_cmp_in(fb), .retrySelIn(retrySel), .insertDoneIn(insDone), .limitActiveIn(limAct),
      .timerCmp(timerCmp), .wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat), .drive(drive),
      .power_good_out(pGood), .alert_out(alert));
   hsc_timer_model model (.clock(clock), .drive(drive), .timerCmp(timerCmp));

   ////////////////////////////////////////////////////////////////////////////////
   // Counts retry charge-up ramps; gate off with timer charging marks one.
   always @(posedge clock) begin
      rupPrev <= (drive === 7'h30);
      if (drive === 7'h30 && !rupPrev) begin
         ramps <= ramps + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Waits a bounded time for an exact drive pattern; a hang ends the run.
   task automatic wait_drv(input logic [6:0] v);
      int n;
      for (n = 0; n < 3000 && drive !== v; n++) begin
         @(posedge clock);
      end
      chk(drive, v);
      if (n == 3000) begin
         report_and_stop();
      end
   endtask : wait_drv

   // Classic Wishbone cycle, held until ack is sampled, then released.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock);
      wbReq <= {1'b1, 1'b1, w, a, 4'hf, d};
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (wbAck === 1'b1) begin
            break;
         end
      end
      q = wbDat;
      wbReq <= '0;
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
   endtask : wb

   // Brief pull-down of the enable input by an open-drain device.
   task automatic pulse_uv;
      @(posedge clock);
      uv <= 1'b0;
      @(posedge clock);
      uv <= 1'b1;
   endtask : pulse_uv

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      uv = 1'b1;
      ov = 1'b0;
      fb = 1'b1;
      retrySel = 1'b1;
      insDone = 1'b0;
      limAct = 1'b0;
      wbReq = '0;
      repeat (20) @(posedge clock);
      chk({drive, pGood, alert}, 9'h0a0);
      srst <= 1'b0;
      insDone <= 1'b1;
      wait_drv(7'h48);
      // Ordinary supply-window cases.
      for (i = 0; i < 5; i++) begin
         uv <= rows[i].uv;
         ov <= rows[i].ov;
         fb <= rows[i].fb;
         repeat (4) @(posedge clock);
         chk(pGood, rows[i].pg);
         chk(drive, rows[i].drv);
         chk(alert, rows[i].al);
      end
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h5f);
      wb(1'b1, 8'h04, 32'h1f, rd);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h40);
      chk(alert, 1'b0);
      // Masked undervolt alert still sets the flags.
      wb(1'b1, 8'h00, 32'h10, rd);
      pulse_uv();
      repeat (3) @(posedge clock);
      chk(alert, 1'b0);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h4d);
      wb(1'b1, 8'h04, 32'h1f, rd);
      wb(1'b1, 8'h00, 32'h0, rd);
      wb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0);
      // Latch-off with the retry pin high, then restart by a short enable pull-down.
      limAct <= 1'b1;
      wait_drv(7'h50);
      wait_drv(7'h24);
      limAct <= 1'b0;
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h60);
      pulse_uv();
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h6d);
      wait_drv(7'h48);
      wb(1'b1, 8'h04, 32'h1f, rd);
      // Automatic retry with the pin low while the fault persists.
      retrySel <= 1'b0;
      limAct <= 1'b1;
      r0 = ramps;
      wait_drv(7'h24);
      wait_drv(7'h48);
      chk(32'(ramps - r0), 7);
      wait_drv(7'h50);
      limAct <= 1'b0;
      wait_drv(7'h48);
      // Register override with zero retries beats the pin.
      wb(1'b1, 8'h00, 32'h01, rd);
      limAct <= 1'b1;
      wait_drv(7'h24);
      limAct <= 1'b0;
      repeat (10) @(posedge clock);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h60);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk(rd, 32'h1);
      // Supply cycling: a reset in mid-run clears the latch and powers up afresh.
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      chk({drive, pGood, alert}, 9'h0a0);
      srst <= 1'b0;
      wait_drv(7'h48);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h40);
      // Masked overvoltage alert still sets the flags.
      wb(1'b1, 8'h00, 32'h20, rd);
      @(posedge clock);
      ov <= 1'b1;
      @(posedge clock);
      ov <= 1'b0;
      repeat (3) @(posedge clock);
      chk(alert, 1'b0);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h56);
      // Register override with one retry: one restart, then the latch.
      wb(1'b1, 8'h04, 32'h1f, rd);
      wb(1'b1, 8'h00, 32'h03, rd);
      limAct <= 1'b1;
      wait_drv(7'h24);
      wait_drv(7'h48);
      wait_drv(7'h24);
      limAct <= 1'b0;
      repeat (10) @(posedge clock);
      wb(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'h60);
      report_and_stop();
   end
endmodule : test_hot_swap_fault_restart_control
`default_nettype wire
